// [core/ddrpa_pkg.sv]
// constants, types and helper functions for the ddr port priority arbiter
// Operation
// - eight paths: 0-3 read sides of ports 0-3, 4-7 write sides
// - each path owns an independently configured priority generator
// - each generator yields one of four levels, zero lowest, three highest
// - a disabled generator always presents the lowest level
// - higher pending levels are granted before lower ones
// - all-lowest pending requests are granted round-robin, one per path
// - a path at the highest level shares grants round-robin with other top-level paths while it stays there
// - every request is timestamped on entering its path queue
// - head timer is mapped to a level through per-path thresholds
// - timers advance once per 240 MHz base-clock cycle
// - timers count down, signed range +8192 to -8192
// - a timer crossing zero while waiting is detected and flagged
// - start value sets delay to level two, top limit the delay to three
// - raising the lower-to-1 limit makes requests pass through level one
// - carry-over adds the leftover timer value to the next start value
// - each grant moves up to 128 bytes between master and memory
// - memory data bus is selectable as 16 or 32 bits wide
package ddrpa_pkg;
  localparam int NUM_PATHS = 8;
  localparam int PATH_W = 3;
  localparam int QUEUE_DEPTH = 4;
  localparam logic [2:0] QUEUE_FULL_CNT = 3'h4;
  localparam logic [2:0] QUEUE_NEAR_CNT = 3'h3;
  localparam int CLK_MHZ = 250;
  localparam int BASE_MHZ = 240;
  localparam logic [8:0] PHASE_STEP = 9'(BASE_MHZ);
  localparam logic [8:0] PHASE_WRAP = 9'(CLK_MHZ);
  localparam int XFER_BYTES = 128;
  localparam logic [6:0] BEATS_16 = 7'(XFER_BYTES * 8 / 16);
  localparam logic [6:0] BEATS_32 = 7'(XFER_BYTES * 8 / 32);
  localparam logic signed [14:0] TIMER_MAX = 15'sh2000;
  localparam logic signed [14:0] TIMER_MIN = 15'sh6000;
  localparam logic signed [17:0] SAT_HI = 18'sh02000;
  localparam logic signed [17:0] SAT_LO = 18'sh3e000;
  localparam logic [7:0] OFS_GLOBAL = 8'h80;
  localparam logic [3:0] OFS_CFG = 4'h0;
  localparam logic [3:0] OFS_LIMA = 4'h4;
  localparam logic [3:0] OFS_LIMB = 4'h8;
  localparam logic [3:0] OFS_STATUS = 4'hc;
  localparam int CFG_EN_BIT = 0;
  localparam int CFG_CARRY_BIT = 1;
  localparam int HI_LSB = 16;
  localparam int ST_CROSSED_BIT = 2;
  localparam int GLB_WIDTH_BIT = 0;
  localparam logic signed [14:0] RST_START = 15'sh0000;
  localparam logic signed [14:0] RST_LIM01 = 15'sh0001;
  localparam logic signed [14:0] RST_LIM12 = 15'sh0000;
  localparam logic signed [14:0] RST_LIM23 = 15'sh7fff;
  localparam logic RST_WIDTH32 = 1'b0;

  typedef logic signed [14:0] ddrpa_timer_t;
  typedef enum logic [1:0] {
    LEVEL_LOWEST = 2'h0,
    LEVEL_ONE = 2'h1,
    LEVEL_TWO = 2'h2,
    LEVEL_HIGHEST = 2'h3
  } ddrpa_level_t;
  typedef struct packed {
    logic enable;
    logic carry;
    ddrpa_timer_t start;
    ddrpa_timer_t lower_to_level1_limit;
    ddrpa_timer_t level1_to_level2_limit;
    ddrpa_timer_t level2_to_top_limit;
  } ddrpa_cfg_t;
  typedef struct packed {
    logic [7:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
  } ddrpa_avm_req_t;
  typedef struct packed {
    logic waitrequest;
    logic [31:0] readdata;
  } ddrpa_avm_rsp_t;
  typedef struct packed {
    logic valid;
    logic [2:0] path;
    logic [6:0] beats;
  } ddrpa_grant_t;
  typedef struct packed {
    ddrpa_level_t level;
    ddrpa_timer_t timer;
    logic [2:0] pending;
    logic full;
    logic crossed;
  } ddrpa_gen_status_t;
  typedef struct packed {
    logic [3:0][15:0] stamp;
    logic [1:0] rd;
    logic [1:0] wr;
    logic [2:0] count;
    ddrpa_timer_t timer;
    ddrpa_timer_t carry;
  } ddrpa_gen_state_t;

  function automatic ddrpa_timer_t ddrpa_sat(input logic signed [17:0] v);
    if (v > SAT_HI) begin
      return TIMER_MAX;
    end else if (v < SAT_LO) begin
      return TIMER_MIN;
    end
    return v[14:0];
  endfunction

  function automatic ddrpa_level_t ddrpa_level(input ddrpa_cfg_t c, input ddrpa_timer_t t);
    if (!c.enable) begin
      return LEVEL_LOWEST;
    end else if (t <= c.level2_to_top_limit) begin
      return LEVEL_HIGHEST;
    end else if (t <= c.level1_to_level2_limit) begin
      return LEVEL_TWO;
    end else if (t < c.lower_to_level1_limit) begin
      return LEVEL_ONE;
    end
    return LEVEL_LOWEST;
  endfunction
endpackage

// [core/ddrpa_gen.sv]
// per-path priority generator with request queue and age timer
`timescale 1ns/1ps
module ddrpa_gen (
  input wire logic clk,
  input wire logic resetn,
  input wire logic tick,
  input wire logic [15:0] now,
  input ddrpa_pkg::ddrpa_cfg_t cfg,
  input wire logic push,
  input wire logic pop,
  output ddrpa_pkg::ddrpa_gen_status_t status
);
  import ddrpa_pkg::*;

  ddrpa_gen_state_t s;
  ddrpa_gen_state_t n;
  logic crossed;
  logic signed [17:0] load_val;
  ddrpa_timer_t leftover;
  logic [15:0] age;
  logic [2:0] cnt_tmp;

  always_comb begin
    n = s;
    crossed = 1'b0;
    leftover = '0;
    load_val = '0;
    age = '0;
    cnt_tmp = s.count;
    if (push && s.count != QUEUE_FULL_CNT) begin
      n.stamp[s.wr] = now;
      n.wr = s.wr + 2'h1;
      cnt_tmp = cnt_tmp + 3'h1;
    end
    if (tick && s.count != 3'h0) begin
      if (s.timer != TIMER_MIN) begin
        n.timer = s.timer - 15'sh0001;
      end
      crossed = (s.timer == 15'sh0000);
    end
    if (pop && s.count != 3'h0) begin
      leftover = n.timer;
      n.rd = s.rd + 2'h1;
      cnt_tmp = cnt_tmp - 3'h1;
      if (cnt_tmp != 3'h0) begin
        age = now - n.stamp[n.rd];
        load_val = 18'(cfg.start) - $signed({2'b00, age});
        if (cfg.carry) begin
          load_val = load_val + 18'(leftover);
        end
        n.timer = ddrpa_sat(load_val);
        n.carry = '0;
      end else begin
        n.carry = cfg.carry ? leftover : '0;
      end
    end else if (s.count == 3'h0 && cnt_tmp != 3'h0) begin
      load_val = 18'(cfg.start) + 18'(s.carry);
      n.timer = ddrpa_sat(load_val);
      n.carry = '0;
    end
    n.count = cnt_tmp;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  // head of queue is the oldest request
  assign status.level = (s.count != 3'h0) ? ddrpa_level(cfg, s.timer) : LEVEL_LOWEST;
  assign status.timer = s.timer;
  assign status.pending = s.count;
  assign status.full = (s.count >= QUEUE_NEAR_CNT);
  assign status.crossed = crossed;

  disabled_low_a: assert property (@(posedge clk) disable iff (!resetn)
    !cfg.enable |-> status.level == LEVEL_LOWEST)
    else $error("disabled generator shows a raised level");

  timer_step_a: assert property (@(posedge clk) disable iff (!resetn)
    tick && s.count != 3'h0 && !pop && s.timer != TIMER_MIN
    |=> s.timer == $past(s.timer) - 15'sh0001)
    else $error("timer did not step down by one on a base tick");

  timer_range_a: assert property (@(posedge clk) disable iff (!resetn)
    s.timer >= TIMER_MIN && s.timer <= TIMER_MAX)
    else $error("timer left its signed range");

  crossed_sign_a: assert property (@(posedge clk) disable iff (!resetn)
    status.crossed && !pop |=> s.timer < 15'sh0000)
    else $error("zero crossing flagged but timer not negative");

  skip_one_a: assert property (@(posedge clk) disable iff (!resetn)
    cfg.lower_to_level1_limit == 15'sh0001 && cfg.level1_to_level2_limit == 15'sh0000
    |-> status.level != LEVEL_ONE)
    else $error("level one reached with skipping thresholds");

  hold_idle_a: assert property (@(posedge clk) disable iff (!resetn)
    s.count == 3'h0 && !push |=> s.count == 3'h0 && $stable(s.timer))
    else $error("idle queue changed state");
endmodule

// [core/ddrpa_arbiter.sv]
// ddr port priority arbiter top with avalon register slave
//
// Design decisions made here: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
module ddrpa_arbiter (
  input wire logic clk,
  input wire logic resetn,
  input ddrpa_pkg::ddrpa_avm_req_t avm_req,
  output ddrpa_pkg::ddrpa_avm_rsp_t avm_rsp,
  input wire logic [7:0] req_push,
  output logic [7:0] queue_full,
  input wire logic mem_ready,
  output ddrpa_pkg::ddrpa_grant_t grant
);
  import ddrpa_pkg::*;

  typedef struct packed {
    ddrpa_cfg_t [NUM_PATHS-1:0] cfg;
    logic width32;
    logic [7:0] crossed;
    logic [2:0] rr_last;
    logic [8:0] phase;
    logic [15:0] now;
    logic tick;
    ddrpa_grant_t grant;
    logic [7:0] full;
    logic waitreq;
    logic [31:0] rdata;
  } ddrpa_top_state_t;

  ddrpa_top_state_t s;
  ddrpa_top_state_t n;
  ddrpa_gen_status_t gst [NUM_PATHS];
  logic [7:0] pop;
  logic [7:0] crossed_clr;
  logic [7:0] crossed_set;
  logic [7:0] pend;
  logic [8:0] phase_sum;
  ddrpa_level_t max_lvl;
  logic [2:0] win;
  logic [2:0] idx;
  logic found;
  logic fire;
  logic higher_pend;
  logic lowest_multi;
  logic [3:0] pend_cnt;
  logic [2:0] path_sel;
  logic [3:0] ofs;
  logic wr_take;
  logic rd_take;
  logic [31:0] rd_word;
  ddrpa_cfg_t cs;
  ddrpa_gen_status_t gs;

  genvar g;
  generate
    for (g = 0; g < NUM_PATHS; g++) begin : gen_path
      ddrpa_gen u_gen (
        .clk(clk),
        .resetn(resetn),
        .tick(s.tick),
        .now(s.now),
        .cfg(s.cfg[g]),
        .push(req_push[g]),
        .pop(pop[g]),
        .status(gst[g])
      );
      assign pend[g] = (gst[g].pending != 3'h0);
      assign crossed_set[g] = gst[g].crossed;
    end
  endgenerate

  always_comb begin
    n = s;
    pop = '0;
    crossed_clr = '0;
    max_lvl = LEVEL_LOWEST;
    win = s.rr_last;
    idx = '0;
    found = 1'b0;
    higher_pend = 1'b0;
    pend_cnt = '0;
    rd_word = '0;
    cs = '0;
    gs = '0;
    path_sel = avm_req.address[6:4];
    ofs = avm_req.address[3:0];

    // base-clock enable, 240 of every 250 cycles
    phase_sum = s.phase + PHASE_STEP;
    if (phase_sum >= PHASE_WRAP) begin
      n.phase = phase_sum - PHASE_WRAP;
      n.tick = 1'b1;
      n.now = s.now + 16'h0001;
    end else begin
      n.phase = phase_sum;
      n.tick = 1'b0;
    end

    // highest pending level, then round-robin inside it
    for (int i = 0; i < NUM_PATHS; i++) begin
      if (pend[i] && gst[i].level > max_lvl) begin
        max_lvl = gst[i].level;
      end
      if (pend[i]) begin
        pend_cnt = pend_cnt + 4'h1;
      end
    end
    for (int k = 1; k <= NUM_PATHS; k++) begin
      idx = 3'(int'(s.rr_last) + k);
      if (!found && pend[idx] && gst[idx].level == max_lvl) begin
        win = idx;
        found = 1'b1;
      end
    end
    for (int i = 0; i < NUM_PATHS; i++) begin
      if (pend[i] && gst[i].level > gst[win].level) begin
        higher_pend = 1'b1;
      end
    end
    lowest_multi = (pend_cnt > 4'h1) && (max_lvl == LEVEL_LOWEST);
    fire = mem_ready && found;
    n.grant.valid = fire;
    if (fire) begin
      pop[win] = 1'b1;
      n.rr_last = win;
      n.grant.path = win;
      n.grant.beats = s.width32 ? BEATS_32 : BEATS_16;
    end

    for (int i = 0; i < NUM_PATHS; i++) begin
      n.full[i] = gst[i].full;
    end

    // register slave, one wait cycle per access
    wr_take = avm_req.write && !s.waitreq;
    rd_take = avm_req.read && s.waitreq;
    n.waitreq = !((avm_req.read || avm_req.write) && s.waitreq);
    cs = s.cfg[path_sel];
    gs = gst[path_sel];
    if (avm_req.address < OFS_GLOBAL) begin
      if (ofs == OFS_CFG) begin
        rd_word = {1'b0, cs.start, 14'h0000, cs.carry, cs.enable};
      end else if (ofs == OFS_LIMA) begin
        rd_word = {1'b0, cs.level1_to_level2_limit, 1'b0, cs.lower_to_level1_limit};
      end else if (ofs == OFS_LIMB) begin
        rd_word = {17'h00000, cs.level2_to_top_limit};
      end else if (ofs == OFS_STATUS) begin
        rd_word = {1'b0, gs.timer, 8'h00, 1'b0, gs.pending, 1'b0, s.crossed[path_sel], gs.level};
      end else begin
        rd_word = '0;
      end
    end else if (avm_req.address == OFS_GLOBAL) begin
      rd_word = {31'h00000000, s.width32};
    end else begin
      rd_word = '0;
    end
    if (rd_take) begin
      n.rdata = rd_word;
    end
    if (wr_take) begin
      if (avm_req.address < OFS_GLOBAL) begin
        if (ofs == OFS_CFG) begin
          n.cfg[path_sel].enable = avm_req.writedata[CFG_EN_BIT];
          n.cfg[path_sel].carry = avm_req.writedata[CFG_CARRY_BIT];
          n.cfg[path_sel].start = avm_req.writedata[HI_LSB +: 15];
        end else if (ofs == OFS_LIMA) begin
          n.cfg[path_sel].lower_to_level1_limit = avm_req.writedata[14:0];
          n.cfg[path_sel].level1_to_level2_limit = avm_req.writedata[HI_LSB +: 15];
        end else if (ofs == OFS_LIMB) begin
          n.cfg[path_sel].level2_to_top_limit = avm_req.writedata[14:0];
        end else if (ofs == OFS_STATUS) begin
          crossed_clr[path_sel] = avm_req.writedata[ST_CROSSED_BIT];
        end
      end else if (avm_req.address == OFS_GLOBAL) begin
        n.width32 = avm_req.writedata[GLB_WIDTH_BIT];
      end
    end
    n.crossed = (s.crossed & ~crossed_clr) | crossed_set;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < NUM_PATHS; i++) begin
        s.cfg[i].enable <= 1'b0;
        s.cfg[i].carry <= 1'b0;
        s.cfg[i].start <= RST_START;
        s.cfg[i].lower_to_level1_limit <= RST_LIM01;
        s.cfg[i].level1_to_level2_limit <= RST_LIM12;
        s.cfg[i].level2_to_top_limit <= RST_LIM23;
      end
      s.width32 <= RST_WIDTH32;
      s.crossed <= '0;
      s.rr_last <= 3'h7;
      s.phase <= '0;
      s.now <= '0;
      s.tick <= 1'b0;
      s.grant <= '0;
      s.full <= '0;
      s.waitreq <= 1'b1;
      s.rdata <= '0;
    end else begin
      s <= n;
    end
  end

  assign avm_rsp.waitrequest = s.waitreq;
  assign avm_rsp.readdata = s.rdata;
  assign queue_full = s.full;
  assign grant = s.grant;

  bus_wait_a: assert property (@(posedge clk) disable iff (!resetn)
    (avm_req.read || avm_req.write) && s.waitreq |=> !s.waitreq)
    else $error("register access not answered after one wait cycle");

  level_order_a: assert property (@(posedge clk) disable iff (!resetn)
    fire |-> !higher_pend)
    else $error("lower level granted over a higher pending level");

  rr_turn_a: assert property (@(posedge clk) disable iff (!resetn)
    fire && lowest_multi |=> s.grant.path != $past(s.rr_last))
    else $error("round-robin granted the same path twice in a row");

  grant_beats_a: assert property (@(posedge clk) disable iff (!resetn)
    s.grant.valid |-> s.grant.beats == ($past(s.width32) ? BEATS_32 : BEATS_16))
    else $error("grant length does not match bus width");

  tick_rate_a: assert property (@(posedge clk) disable iff (!resetn)
    $past(resetn) && !s.tick |=> s.tick)
    else $error("base tick missing for two cycles");

  grant_pend_a: assert property (@(posedge clk) disable iff (!resetn)
    mem_ready && pend != 8'h00 |=> s.grant.valid)
    else $error("pending request not granted while memory ready");

  crossed_keep_a: assert property (@(posedge clk) disable iff (!resetn)
    crossed_set != 8'h00 |=> (s.crossed & $past(crossed_set)) == $past(crossed_set))
    else $error("zero crossing flag lost");
endmodule

// [tb/ddrpa_masters.sv]
// bus master model feeding request pulses into the eight path queues
`timescale 1ns/1ps
module ddrpa_masters (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] queue_full,
  output logic [7:0] req_push
);
  initial req_push = 8'h00;

  // one pulse per request; honour waits while queue_full flags three or more queued requests
  task automatic push(input int p, input bit honour);
    int n;
    @(posedge clk);
    for (n = 0; n < 200 && honour && queue_full[p] !== 1'b0; n++) begin
      @(posedge clk);
    end
    req_push[p] <= 1'b1;
    @(posedge clk);
    req_push[p] <= 1'b0;
  endtask
endmodule

// [tb/testbench.sv]
// self-checking bench for the ddr port priority arbiter
`timescale 1ns/1ps
module testbench;
  import ddrpa_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic mem_ready = 1'b0;
  logic drain = 1'b0;
  logic [7:0] req_push;
  logic [7:0] queue_full;
  ddrpa_avm_req_t avm_req = '0;
  ddrpa_avm_rsp_t avm_rsp;
  ddrpa_grant_t grant;
  logic [9:0] expq[$];
  logic [6:0] beats = BEATS_16;
  logic [31:0] rd;
  logic [9:0] e;
  int mismatches = 0;
  int comparisons = 0;
  integer seed = 52319;

  always #2 clk = ~clk;

  ddrpa_arbiter u_dut (.clk(clk), .resetn(resetn), .avm_req(avm_req), .avm_rsp(avm_rsp),
    .req_push(req_push), .queue_full(queue_full), .mem_ready(mem_ready), .grant(grant));
  ddrpa_masters u_masters (.clk(clk), .resetn(resetn), .queue_full(queue_full),
    .req_push(req_push));

  // memory side stalls at random while draining
  always @(posedge clk) mem_ready <= drain && (($random(seed) & 1) == 1);

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected register value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_grant(input logic [9:0] got, input logic [9:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected grant at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] d,
      output logic [31:0] q);
    int n;
    @(posedge clk);
    avm_req.address <= a;
    avm_req.read <= ~wr;
    avm_req.write <= wr;
    avm_req.writedata <= d;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (avm_rsp.waitrequest === 1'b0) break;
    end
    if (n == 50) mismatches++;
    q = avm_rsp.readdata;
    avm_req.read <= 1'b0;
    avm_req.write <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(a, 1'b1, d, q);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
    bus(a, 1'b0, 32'h0, rd);
    check(rd & m, x);
  endtask

  task automatic want(input logic [2:0] p);
    expq.push_back({p, beats});
  endtask

  task automatic drain_all();
    int n;
    drain <= 1'b1;
    for (n = 0; n < 400 && expq.size() != 0; n++) @(posedge clk);
    if (n == 400) mismatches++;
    drain <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  // grant watcher, oldest note first
  always @(posedge clk) begin
    if (resetn === 1'b1 && grant.valid === 1'b1) begin
      e = 10'h3ff;
      if (expq.size() != 0) e = expq.pop_front();
      check_grant({grant.path, grant.beats}, e);
    end
  end

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    #100000;
    mismatches++;
    tally_and_finish();
  end

  initial begin
    int p;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    rdchk(8'h50, 32'hffffffff, 32'h0);
    rdchk(8'h54, 32'hffffffff, 32'h00000001);
    rdchk(8'h58, 32'hffffffff, 32'h00007fff);
    wr(8'h94, 32'hffffffff);
    rdchk(8'h94, 32'hffffffff, 32'h0);
    $display("test reset values done");
    // all lowest: one grant per path in turn
    for (p = 7; p >= 0; p--) u_masters.push(p, 1'b1);
    for (p = 0; p < 8; p++) want(p[2:0]);
    drain_all();
    wr(8'h80, 32'h1);
    rdchk(8'h80, 32'hffffffff, 32'h1);
    beats = BEATS_32;
    u_masters.push(7, 1'b1);
    u_masters.push(2, 1'b1);
    want(3'h2);
    want(3'h7);
    drain_all();
    $display("test round robin done");
    // four paths at four different levels
    wr(8'h60, 32'h1);
    wr(8'h68, 32'h64);
    wr(8'h50, 32'h1);
    wr(8'h58, 32'h60c0);
    wr(8'h30, 32'h00640001);
    wr(8'h34, 32'hc8);
    wr(8'h38, 32'h60c0);
    u_masters.push(6, 1'b1);
    u_masters.push(6, 1'b1);
    u_masters.push(5, 1'b1);
    u_masters.push(3, 1'b1);
    u_masters.push(0, 1'b1);
    rdchk(8'h6c, 32'h73, 32'h23);
    rdchk(8'h5c, 32'h73, 32'h12);
    rdchk(8'h3c, 32'h73, 32'h11);
    rdchk(8'h0c, 32'h73, 32'h10);
    want(3'h6);
    want(3'h6);
    want(3'h5);
    want(3'h3);
    want(3'h0);
    drain_all();
    $display("test priority levels done");
    // full queue drops the extra request
    for (p = 0; p < 4; p++) u_masters.push(1, 1'b0);
    @(posedge clk);
    check({24'h0, queue_full}, 32'h02);
    u_masters.push(1, 1'b0);
    for (p = 0; p < 4; p++) want(3'h1);
    drain_all();
    $display("test queue full done");
    // late request leaves a negative carry for the next one
    wr(8'h40, 32'h00140003);
    wr(8'h48, 32'h60c0);
    u_masters.push(4, 1'b1);
    repeat (40) @(posedge clk);
    rdchk(8'h4c, 32'h77, 32'h16);
    want(3'h4);
    drain_all();
    // sticky zero-crossing flag clears on a written one
    wr(8'h4c, 32'h4);
    rdchk(8'h4c, 32'h4, 32'h0);
    u_masters.push(0, 1'b1);
    u_masters.push(4, 1'b1);
    repeat (6) @(posedge clk);
    rdchk(8'h4c, 32'h73, 32'h12);
    want(3'h4);
    want(3'h0);
    drain_all();
    $display("test carry over done");
    tally_and_finish();
  end
endmodule
